// file: src/ccc_regs.vh
`ifndef CCC_REGS_VH
`define CCC_REGS_VH
// ==========================================
// Register addresses
`define CCC_ADDR_CH4_SUPPLY   7'h3A
`define CCC_ADDR_COMMON_CTRL  7'h3B
`define CCC_ADDR_RSVD_A       7'h3C
`define CCC_ADDR_RSVD_B       7'h3D
`define CCC_ADDR_RSVD_C       7'h3E
`define CCC_ADDR_RSVD_D       7'h3F
`define CCC_ADDR_DEBUG        7'h42
// ==========================================
// Reset images
`define CCC_RST_CH4_SUPPLY    16'h0008
`define CCC_RST_COMMON_CTRL   16'h0061
`define CCC_RST_RSVD_A        16'h0018
`define CCC_RST_RSVD_B        16'h1500
`define CCC_RST_RSVD_C        16'h4210
`define CCC_RST_RSVD_D        16'h0210
`define CCC_RST_DEBUG         16'h0200
// ==========================================
// Field positions
`define CCC_BIT_LOW_SUPPLY    3
`define CCC_BIT_CHAN_RESET    13
`define CCC_CM_RAISE_HI       12
`define CCC_CM_RAISE_LO       11
`define CCC_CM_LOWER_HI       10
`define CCC_CM_LOWER_LO       9
`define CCC_TAIL_HI           8
`define CCC_TAIL_LO           5
`define CCC_BIT_CMOS_FAST     4
`define CCC_REFDRV_HI         2
`define CCC_REFDRV_LO         1
// ==========================================
// Configuration memory layout
`define CCC_NVM_PAGE_WORDS    64
`define CCC_NVM_BASE_WORDS    12
`define CCC_NVM_CRC_WORD      6'h3F
`endif

// file: src/ccc_reg_cell.v
`timescale 1ns/1ps
// ==========================================
// One 16-bit read-write register with reset image
module ccc_reg_cell #(
  parameter [15:0] RESET_VALUE = 16'h0000
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        writeEn,
  input  wire [15:0] writeData,
  output reg  [15:0] value
);
  always @(posedge clk) begin
    if (reset) begin
      value <= RESET_VALUE;
    end else if (writeEn) begin
      value <= writeData;
    end
  end
endmodule // ccc_reg_cell

// file: src/ccc_common_config.v
`timescale 1ns/1ps
`include "ccc_regs.vh"

// Behaviour
// RQ1 - Bit 3 of the fourth channel supply register flags a 1.8 V supply when set and resets to one.
// RQ2 - Bit 13 of the common control register holds all output channels in reset while set.
// RQ3 - Software programs only one of the common-mode raise or lower fields and leaves the other zero.
// RQ4 - Bits 8-5 select tail current from code C (350 uA) up in 50 uA steps to code 3 (650 uA), reset 3.
// RQ5 - Bit 4 sets CMOS drive of channels one to four, one meaning fast, reset fast; the 61h reset image clears bit 4, so the output goes slow after reset.
// RQ6 - Bits 2-1 control the reference-copy output: 0 off, 1 normal, 3 fast, reset off.
// RQ7 - The common control register sits at 3Bh and resets to 61h.
// RQ8 - The register at 3Dh resets to 1500h.
// RQ9 - Registers at 3Ch, 3Eh and 3Fh reset to 18h, 4210h and 210h.
// RQ10 - The debug register at 42h is 16-bit read-write and resets to 200h.
// RQ11 - Configuration memory holds one base page and two customised pages.
// RQ12 - Customised page 0 is loaded with the select pin low, page 1 with it high.
// RQ13 - The memory checksum lives in word 3Fh of page 1.
// RQ14 - The fourth channel supply register sits at 3Ah and resets to 8h.
// RQ15 - Every register reads back its last written value and returns to its image on reset.
module ccc_common_config (
  input  wire        clk,
  input  wire        reset,
  input  wire [6:0]  regAddr,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [15:0] regWriteData,
  output reg  [15:0] regReadData,
  output reg         regReadValid,
  input  wire        nvmPageSelectPin,
  output reg         nvmCustomPage,
  output reg  [6:0]  nvmCrcWordAddr,
  output reg         fourthChannelLowSupplyFlag,
  output reg         channelReset,
  output reg  [1:0]  cmTrimRaise,
  output reg  [1:0]  cmTrimLower,
  output reg  [3:0]  tailCurrentCode,
  output reg  [9:0]  tailCurrentMicroAmp,
  output reg         cmosDriveFast,
  output reg         referenceCopyOutputEnable,
  output reg         refCopyOutputDriveFast
);

  // ==========================================
  // Write decode
  wire        writeFourthChannelSupply;
  wire        writeChannelCommonControl;
  wire        writeChannelCommonReservedA;
  wire        writeChannelCommonReservedB;
  wire        writeChannelCommonReservedC;
  wire        writeChannelCommonReservedD;
  wire        writeDebugReserved;

  assign writeFourthChannelSupply    = regWrite && (regAddr == `CCC_ADDR_CH4_SUPPLY);
  assign writeChannelCommonControl   = regWrite && (regAddr == `CCC_ADDR_COMMON_CTRL);
  assign writeChannelCommonReservedA = regWrite && (regAddr == `CCC_ADDR_RSVD_A);
  assign writeChannelCommonReservedB = regWrite && (regAddr == `CCC_ADDR_RSVD_B);
  assign writeChannelCommonReservedC = regWrite && (regAddr == `CCC_ADDR_RSVD_C);
  assign writeChannelCommonReservedD = regWrite && (regAddr == `CCC_ADDR_RSVD_D);
  assign writeDebugReserved          = regWrite && (regAddr == `CCC_ADDR_DEBUG);

  // ==========================================
  // Register storage
  wire [15:0] fourthChannelSupplyConfig;
  wire [15:0] channelCommonControl;
  wire [15:0] channelCommonReservedA;
  wire [15:0] channelCommonReservedB;
  wire [15:0] channelCommonReservedC;
  wire [15:0] channelCommonReservedD;
  wire [15:0] debugReserved;

  ccc_reg_cell #(
    .RESET_VALUE (`CCC_RST_CH4_SUPPLY)
  ) uFourthChannelSupply ( // [RQ14] [RQ15]
    .clk       (clk),
    .reset     (reset),
    .writeEn   (writeFourthChannelSupply),
    .writeData (regWriteData),
    .value     (fourthChannelSupplyConfig)
  );

  ccc_reg_cell #(
    .RESET_VALUE (`CCC_RST_COMMON_CTRL)
  ) uChannelCommonControl ( // [RQ7] [RQ15]
    .clk       (clk),
    .reset     (reset),
    .writeEn   (writeChannelCommonControl),
    .writeData (regWriteData),
    .value     (channelCommonControl)
  );

  ccc_reg_cell #(
    .RESET_VALUE (`CCC_RST_RSVD_A)
  ) uChannelCommonReservedA ( // [RQ9] [RQ15]
    .clk       (clk),
    .reset     (reset),
    .writeEn   (writeChannelCommonReservedA),
    .writeData (regWriteData),
    .value     (channelCommonReservedA)
  );

  ccc_reg_cell #(
    .RESET_VALUE (`CCC_RST_RSVD_B)
  ) uChannelCommonReservedB ( // [RQ8] [RQ15]
    .clk       (clk),
    .reset     (reset),
    .writeEn   (writeChannelCommonReservedB),
    .writeData (regWriteData),
    .value     (channelCommonReservedB)
  );

  ccc_reg_cell #(
    .RESET_VALUE (`CCC_RST_RSVD_C)
  ) uChannelCommonReservedC ( // [RQ9] [RQ15]
    .clk       (clk),
    .reset     (reset),
    .writeEn   (writeChannelCommonReservedC),
    .writeData (regWriteData),
    .value     (channelCommonReservedC)
  );

  ccc_reg_cell #(
    .RESET_VALUE (`CCC_RST_RSVD_D)
  ) uChannelCommonReservedD ( // [RQ9] [RQ15]
    .clk       (clk),
    .reset     (reset),
    .writeEn   (writeChannelCommonReservedD),
    .writeData (regWriteData),
    .value     (channelCommonReservedD)
  );

  ccc_reg_cell #(
    .RESET_VALUE (`CCC_RST_DEBUG)
  ) uDebugReserved ( // [RQ10] [RQ15]
    .clk       (clk),
    .reset     (reset),
    .writeEn   (writeDebugReserved),
    .writeData (regWriteData),
    .value     (debugReserved)
  );

  // ==========================================
  // Read mux
  reg [15:0] next_readData;
  always @* begin
    case (regAddr)
      `CCC_ADDR_CH4_SUPPLY:  next_readData = fourthChannelSupplyConfig;
      `CCC_ADDR_COMMON_CTRL: next_readData = channelCommonControl;
      `CCC_ADDR_RSVD_A:      next_readData = channelCommonReservedA;
      `CCC_ADDR_RSVD_B:      next_readData = channelCommonReservedB;
      `CCC_ADDR_RSVD_C:      next_readData = channelCommonReservedC;
      `CCC_ADDR_RSVD_D:      next_readData = channelCommonReservedD;
      `CCC_ADDR_DEBUG:       next_readData = debugReserved;
      default:               next_readData = 16'h0000;
    endcase
  end

  // ==========================================
  // Read data register
  always @(posedge clk) begin
    if (reset) begin
      regReadData  <= 16'h0000;
      regReadValid <= 1'h0;
    end else begin
      regReadValid <= regRead;
      if (regRead) begin
        regReadData <= next_readData; // [RQ15]
      end
    end
  end

  // ==========================================
  // Tail current decode
  reg [9:0] next_tailUa;
  always @* begin
    case (channelCommonControl[`CCC_TAIL_HI:`CCC_TAIL_LO])
      4'hC:    next_tailUa = 10'h15E;
      4'h8:    next_tailUa = 10'h190;
      4'h4:    next_tailUa = 10'h1C2;
      4'h0:    next_tailUa = 10'h1F4;
      4'h1:    next_tailUa = 10'h226;
      4'h2:    next_tailUa = 10'h258;
      4'h3:    next_tailUa = 10'h28A;
      default: next_tailUa = 10'h1F4;
    endcase
  end

  // ==========================================
  // Reference-copy output decode
  reg next_refEnable;
  reg next_refFast;
  always @* begin
    next_refEnable = 1'h0;
    next_refFast   = 1'h0;
    case (channelCommonControl[`CCC_REFDRV_HI:`CCC_REFDRV_LO])
      2'h1: begin
        next_refEnable = 1'h1;
        next_refFast   = 1'h0;
      end
      2'h3: begin
        next_refEnable = 1'h1;
        next_refFast   = 1'h1;
      end
      default: begin
        next_refEnable = 1'h0;
        next_refFast   = 1'h0;
      end
    endcase
  end

  // ==========================================
  // Page select pin synchroniser
  reg pageSync1;
  reg pageSync2;
  always @(posedge clk) begin
    if (reset) begin
      pageSync1 <= 1'h0;
      pageSync2 <= 1'h0;
    end else begin
      pageSync1 <= nvmPageSelectPin;
      pageSync2 <= pageSync1;
    end
  end

  // ==========================================
  // Fourth channel supply flag
  always @(posedge clk) begin
    if (reset) begin
      fourthChannelLowSupplyFlag <= 1'h1;
    end else begin
      fourthChannelLowSupplyFlag <= fourthChannelSupplyConfig[`CCC_BIT_LOW_SUPPLY]; // [RQ1]
    end
  end

  // ==========================================
  // Channel reset
  always @(posedge clk) begin
    if (reset) begin
      channelReset <= 1'h0;
    end else begin
      channelReset <= channelCommonControl[`CCC_BIT_CHAN_RESET]; // [RQ2]
    end
  end

  // ==========================================
  // Common-mode trims
  always @(posedge clk) begin
    if (reset) begin
      cmTrimRaise <= 2'h0;
      cmTrimLower <= 2'h0;
    end else begin
      cmTrimRaise <= channelCommonControl[`CCC_CM_RAISE_HI:`CCC_CM_RAISE_LO];
      cmTrimLower <= channelCommonControl[`CCC_CM_LOWER_HI:`CCC_CM_LOWER_LO];
    end
  end

  // ==========================================
  // Tail current
  always @(posedge clk) begin
    if (reset) begin
      tailCurrentCode     <= 4'h3;
      tailCurrentMicroAmp <= 10'h28A;
    end else begin
      tailCurrentCode     <= channelCommonControl[`CCC_TAIL_HI:`CCC_TAIL_LO]; // [RQ4]
      tailCurrentMicroAmp <= next_tailUa; // [RQ4]
    end
  end

  // ==========================================
  // Channel CMOS drive strength
  always @(posedge clk) begin
    if (reset) begin
      cmosDriveFast <= 1'h1;
    end else begin
      cmosDriveFast <= channelCommonControl[`CCC_BIT_CMOS_FAST]; // [RQ5]
    end
  end

  // ==========================================
  // Reference-copy output
  always @(posedge clk) begin
    if (reset) begin
      referenceCopyOutputEnable <= 1'h0;
      refCopyOutputDriveFast    <= 1'h0;
    end else begin
      referenceCopyOutputEnable <= next_refEnable; // [RQ6]
      refCopyOutputDriveFast    <= next_refFast; // [RQ6]
    end
  end

  // ==========================================
  // Configuration memory page choice
  always @(posedge clk) begin
    if (reset) begin
      nvmCustomPage <= 1'h0;
    end else begin
      nvmCustomPage <= pageSync2; // [RQ12] [RQ11]
    end
  end

  // ==========================================
  // Configuration memory checksum location
  always @(posedge clk) begin
    if (reset) begin
      nvmCrcWordAddr <= 7'h00;
    end else begin
      nvmCrcWordAddr <= {1'h1, `CCC_NVM_CRC_WORD}; // [RQ13]
    end
  end

endmodule // ccc_common_config

// file: verif/ccc_common_config_asserts.sv
`timescale 1ns/1ps
// ==========================================
// Checker
module ccc_common_config_asserts (
  input logic        clk,
  input logic        reset,
  input logic [6:0]  regAddr,
  input logic        regWrite,
  input logic        regRead,
  input logic [15:0] regWriteData,
  input logic        regReadValid,
  input logic        nvmPageSelectPin,
  input logic        nvmCustomPage,
  input logic [6:0]  nvmCrcWordAddr,
  input logic        fourthChannelLowSupplyFlag,
  input logic        channelReset,
  input logic [3:0]  tailCurrentCode,
  input logic        cmosDriveFast,
  input logic        referenceCopyOutputEnable,
  input logic        refCopyOutputDriveFast
);
  logic [2:0] relCnt;
  always_ff @(posedge clk)
    if (reset) relCnt <= 3'h0;
    else if (relCnt != 3'h4) relCnt <= relCnt + 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_wr(logic [6:0] a);
    regWrite && regAddr == a ##1 1'b1;
  endsequence
  a_read_valid: assert property (regRead |=> regReadValid)
    else $error("read valid missing");
  a_chan_reset: assert property (s_wr(7'h3B) |=> channelReset == $past(regWriteData[13], 2))
    else $error("channel reset wrong");
  a_tail_code: assert property (s_wr(7'h3B) |=> tailCurrentCode == $past(regWriteData[8:5], 2))
    else $error("tail code wrong");
  a_cmos_drive: assert property (s_wr(7'h3B) |=> cmosDriveFast == $past(regWriteData[4], 2))
    else $error("cmos drive wrong");
  a_ref_fast: assert property (s_wr(7'h3B) |=> refCopyOutputDriveFast == ($past(regWriteData[2:1], 2) == 2'h3))
    else $error("ref drive wrong");
  a_ref_enable: assert property (s_wr(7'h3B) |=> referenceCopyOutputEnable == $past(regWriteData[1], 2))
    else $error("ref enable wrong");
  a_low_supply: assert property (s_wr(7'h3A) |=> fourthChannelLowSupplyFlag == $past(regWriteData[3], 2))
    else $error("supply flag wrong");
  a_page_sync: assert property (relCnt == 3'h4 |-> nvmCustomPage == $past(nvmPageSelectPin, 3))
    else $error("page select wrong");
  a_crc_word: assert property (relCnt == 3'h4 |-> nvmCrcWordAddr == 7'h7F)
    else $error("crc word wrong");
endmodule // ccc_common_config_asserts

// file: verif/ccc_testbench.sv
`timescale 1ns/1ps
// ==========================================
// Testbench
module testbench;
  logic        clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, nvmPageSelectPin = 1'b0;
  logic [6:0]  regAddr = 7'h00, nvmCrcWordAddr;
  logic [15:0] regWriteData = 16'h0000, regReadData;
  logic        regReadValid, nvmCustomPage, fourthChannelLowSupplyFlag, channelReset, cmosDriveFast;
  logic        referenceCopyOutputEnable, refCopyOutputDriveFast;
  logic [1:0]  cmTrimRaise, cmTrimLower;
  logic [3:0]  tailCurrentCode;
  logic [9:0]  tailCurrentMicroAmp;
  int          errTotal = 0, checked = 0;
  logic [6:0]  addrs [7] = '{7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F, 7'h42};
  logic [15:0] imgs [7] = '{16'h0008, 16'h0061, 16'h0018, 16'h1500, 16'h4210, 16'h0210, 16'h0200};
  logic [3:0]  codes [7] = '{4'hC, 4'h8, 4'h4, 4'h0, 4'h1, 4'h2, 4'h3};
  ccc_common_config i_dut (.*);
  always #5 clk = ~clk;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errTotal++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rst(input int n);
    @(posedge clk);
    reset <= 1'b1;
    repeat (n) @(posedge clk);
    reset <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk("valid", 16'h0001, {15'h0000, regReadValid});
    chk("data", e, regReadData);
  endtask
  task automatic t_images;
    for (int i = 0; i < 7; i++) rd(addrs[i], imgs[i]);
    chk("flag", 16'h0001, {15'h0000, fourthChannelLowSupplyFlag});
    chk("tail", 16'h028A, {6'h00, tailCurrentMicroAmp});
    chk("cmos", 16'h0000, {15'h0000, cmosDriveFast});
    chk("ref", 16'h0000, {15'h0000, referenceCopyOutputEnable});
    $display("test images done");
  endtask
  task automatic t_access;
    logic [15:0] d;
    for (int i = 0; i < 7; i++) begin
      d = (i == 1) ? 16'hF99E : ~imgs[i];
      wr(addrs[i], d);
      rd(addrs[i], d);
    end
    wr(7'h40, 16'hFFFF);
    rd(7'h40, 16'h0000);
    chk("flag", 16'h0000, {15'h0000, fourthChannelLowSupplyFlag});
    chk("chanRst", 16'h0001, {15'h0000, channelReset});
    $display("test access done");
  endtask
  task automatic t_fields;
    for (int i = 0; i < 7; i++) begin
      wr(7'h3B, {7'h00, codes[i], 5'h00});
      rd(7'h3B, {7'h00, codes[i], 5'h00});
      chk("tail", 16'(16'h015E + 16'h0032 * i), {6'h00, tailCurrentMicroAmp});
    end
    chk("chanRst", 16'h0000, {15'h0000, channelReset});
    chk("cmos", 16'h0000, {15'h0000, cmosDriveFast});
    for (int m = 0; m < 4; m += m + 1) begin
      wr(7'h3B, 16'(m * 2));
      rd(7'h3B, 16'(m * 2));
      chk("ref", {14'h0000, m == 3, m != 0}, {14'h0000, refCopyOutputDriveFast, referenceCopyOutputEnable});
    end
    wr(7'h3B, 16'h1000);
    rd(7'h3B, 16'h1000);
    chk("cmTrim", 16'h0008, {12'h000, cmTrimRaise, cmTrimLower});
    wr(7'h3B, 16'h0400);
    rd(7'h3B, 16'h0400);
    chk("cmTrim", 16'h0002, {12'h000, cmTrimRaise, cmTrimLower});
    $display("test fields done");
  endtask
  task automatic t_page;
    for (int p = 1; p >= 0; p--) begin
      @(posedge clk);
      nvmPageSelectPin <= p[0];
      repeat (4) @(posedge clk);
      #1;
      chk("page", 16'(p), {15'h0000, nvmCustomPage});
    end
    chk("crc", 16'h007F, {9'h000, nvmCrcWordAddr});
    wr(7'h42, 16'h1234);
    rst(2);
    #1;
    chk("cmos", 16'h0001, {15'h0000, cmosDriveFast});
    chk("flag", 16'h0001, {15'h0000, fourthChannelLowSupplyFlag});
    chk("chanRst", 16'h0000, {15'h0000, channelReset});
    rd(7'h42, 16'h0200);
    rd(7'h3B, 16'h0061);
    $display("test page done");
  endtask
  task automatic testDone;
    $display("comparisons %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    errTotal++;
    testDone();
  end
  initial begin
    rst(12);
    t_images();
    t_access();
    t_fields();
    t_page();
    testDone();
  end
endmodule // testbench
bind ccc_common_config ccc_common_config_asserts i_chk (.*);
